// ===== pkg/rxpr_pkg.sv
// rxpr_pkg: constants and carriers for the receive packetizer register bank
// assumes a byte-addressed plain register port with 32-bit data
package rxpr_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    localparam logic [ADDR_W-1:0] OFS_BLOCK     = 8'hc4;
    localparam logic [ADDR_W-1:0] OFS_NODE_HIGH = 8'hc8;
    localparam logic [ADDR_W-1:0] OFS_OFS_LOW   = 8'hcc;
    localparam logic [ADDR_W-1:0] OFS_HDR0      = 8'hd0;
    localparam logic [ADDR_W-1:0] OFS_HDR1      = 8'hd4;
    localparam logic [ADDR_W-1:0] OFS_HDR2      = 8'hd8;
    localparam logic [ADDR_W-1:0] OFS_HDR3      = 8'hdc;
    localparam logic [ADDR_W-1:0] OFS_TRAILER   = 8'he0;
    // own control word: mode, long block, header strip
    localparam logic [ADDR_W-1:0] OFS_CTRL      = 8'hb0;

    localparam int CTRL_PKTZ_BIT  = 0;
    localparam int CTRL_LNG_BIT   = 1;
    localparam int CTRL_STRIP_BIT = 2;

    localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
    localparam logic [DATA_W-1:0] ONE_WORD = 32'h0000_0001;
    localparam int HDR_N = 4;

    // msb-first bit numbering: doc bit n sits at vector bit 31-n
    localparam int NODE_ID_W = 17;
    localparam int OFS_HI_W  = 15;

    // trailer field low ends in vector numbering
    localparam int TRL_SPD_LSB  = DATA_W - 1 - 15;
    localparam int TRL_FILL_LSB = DATA_W - 1 - 23;
    localparam int TRL_ACK_LSB  = DATA_W - 1 - 31;

    typedef logic [1:0] rxpr_speed_t;  // 00=100 01=200 10=400 11 invalid
    typedef logic [1:0] rxpr_fill_t;   // 00 none 01 three 10 two 11 one
    typedef logic [3:0] rxpr_ack_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } rxpr_bus_s;

    typedef struct packed {
        logic        valid;
        logic [1:0]  index;
        logic [31:0] quadlet;
    } rxpr_hdr_s;

    typedef struct packed {
        logic        valid;
        rxpr_speed_t speed;
        rxpr_fill_t  fill;
        rxpr_ack_t   ack;
    } rxpr_trl_s;

    typedef enum logic [1:0] {
        RXPR_IDLE = 2'b00,
        RXPR_HDR  = 2'b01,
        RXPR_DONE = 2'b10
    } rxpr_cap_e;
endpackage

// ===== hdl/rxpr_regs.sv
// rxpr_regs: receive packetizer register bank, header capture and trailer
// assumes receive engine on clk; sw port reads answer one cycle later
// Overview of operation
// RULE_01: long block bit 1 makes the block register the block size.
// RULE_02: long block bit 0 makes the block register the block count.
// RULE_03: block count decrements by itself on each received block; the code stops decrementing and holds the count once it reaches zero.
// RULE_04: block size value is counted in bytes.
// RULE_05: target node id lives in bits 0 to 16 of the node register.
// RULE_06: high offset lives in bits 17 to 31 of that register.
// RULE_07: low 32 offset bits live in their own rw register.
// RULE_08: header strip on writes stripped headers into capture registers.
// RULE_09: quadlets zero to three go to rising offsets, readable once copied.
// RULE_10: capture registers reset to zero; bus reset leaves them.
// RULE_11: trailer resets to zero; bus reset leaves it.
// RULE_12: trailer bits 14-15 give response speed code.
// RULE_13: trailer bits 22-23 give zero-fill byte code.
// RULE_14: trailer bits 28-31 give the request ack code.
// RULE_15: control registers reset to zero, bus reset does not touch them.
// RULE_16: control registers act only while packetizer mode is set.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
module rxpr_regs
    import rxpr_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire rxpr_pkg::rxpr_bus_s        bus,
    output logic [rxpr_pkg::DATA_W-1:0]     rdata_ff,
    input  wire logic                       bus_reset,
    input  wire logic                       block_done,
    input  wire rxpr_pkg::rxpr_hdr_s        hdr_in,
    input  wire rxpr_pkg::rxpr_trl_s        trl_in,
    output logic                            pktz_mode_ff,
    output logic                            block_is_size_ff,
    output logic                            count_zero_ff,
    output logic [rxpr_pkg::DATA_W-1:0]     block_value_ff,
    output logic [rxpr_pkg::NODE_ID_W-1:0]  target_node_id_ff,
    output logic [47:0]                     target_offset_ff
);
    import rxpr_pkg::*;

    logic [DATA_W-1:0] ctrl_ff;
    logic [DATA_W-1:0] block_ff;
    logic [DATA_W-1:0] node_high_ff;
    logic [DATA_W-1:0] ofs_low_ff;
    logic [DATA_W-1:0] hdr_ff [HDR_N];
    logic [DATA_W-1:0] trailer_ff;
    logic [DATA_W-1:0] nxt_rdata;

    logic pktz;
    logic lng;
    logic strip;
    assign pktz  = ctrl_ff[CTRL_PKTZ_BIT];
    assign lng   = ctrl_ff[CTRL_LNG_BIT];
    assign strip = ctrl_ff[CTRL_STRIP_BIT];

    // bus reset is ignored on purpose: these words survive it
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_ff <= RST_WORD;
        end else if (bus.wr && bus.addr == OFS_CTRL) begin
            ctrl_ff <= bus.wdata;
        end
    end

    // sw write wins over a same-cycle decrement; sw reloads the count
    always_ff @(posedge clk) begin
        if (rst) begin
            block_ff <= RST_WORD; // RULE_15
        end else if (bus.wr && bus.addr == OFS_BLOCK) begin
            block_ff <= bus.wdata;
        end else if (pktz && !lng && block_done && block_ff != RST_WORD) begin // RULE_16
            block_ff <= block_ff - ONE_WORD; // RULE_02 RULE_03
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            node_high_ff <= RST_WORD; // RULE_15
            ofs_low_ff   <= RST_WORD; // RULE_15
        end else if (bus.wr) begin
            if (bus.addr == OFS_NODE_HIGH) begin
                node_high_ff <= bus.wdata; // RULE_05 RULE_06
            end
            if (bus.addr == OFS_OFS_LOW) begin
                ofs_low_ff <= bus.wdata; // RULE_07
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < HDR_N; gi++) begin : g_hdr
            always_ff @(posedge clk) begin
                if (rst) begin
                    hdr_ff[gi] <= RST_WORD; // RULE_10
                end else if (pktz && strip && hdr_in.valid
                             && hdr_in.index == 2'(gi)) begin // RULE_08
                    hdr_ff[gi] <= hdr_in.quadlet; // RULE_09
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            trailer_ff <= RST_WORD; // RULE_11
        end else if (pktz && trl_in.valid) begin
            trailer_ff               <= RST_WORD;
            trailer_ff[TRL_SPD_LSB +: $bits(rxpr_speed_t)] <= trl_in.speed; // RULE_12
            trailer_ff[TRL_FILL_LSB +: $bits(rxpr_fill_t)] <= trl_in.fill; // RULE_13
            trailer_ff[TRL_ACK_LSB +: $bits(rxpr_ack_t)]   <= trl_in.ack; // RULE_14
        end
    end

    always_comb begin
        nxt_rdata = RST_WORD;
        unique case (bus.addr)
            OFS_CTRL:      nxt_rdata = ctrl_ff;
            OFS_BLOCK:     nxt_rdata = block_ff;
            OFS_NODE_HIGH: nxt_rdata = node_high_ff;
            OFS_OFS_LOW:   nxt_rdata = ofs_low_ff;
            OFS_HDR0:      nxt_rdata = hdr_ff[0];
            OFS_HDR1:      nxt_rdata = hdr_ff[1];
            OFS_HDR2:      nxt_rdata = hdr_ff[2];
            OFS_HDR3:      nxt_rdata = hdr_ff[3];
            OFS_TRAILER:   nxt_rdata = trailer_ff;
            default:       nxt_rdata = RST_WORD;
        endcase
    end

    // read data valid only the cycle after the strobe, zero otherwise
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_ff <= RST_WORD;
        end else begin
            rdata_ff <= bus.rd ? nxt_rdata : RST_WORD;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pktz_mode_ff      <= 1'b0;
            block_is_size_ff  <= 1'b0;
            count_zero_ff     <= 1'b0;
            block_value_ff    <= RST_WORD;
            target_node_id_ff <= '0;
            target_offset_ff  <= '0;
        end else begin
            pktz_mode_ff      <= pktz; // RULE_16
            block_is_size_ff  <= pktz && lng; // RULE_01 RULE_04
            count_zero_ff     <= pktz && !lng && block_ff == RST_WORD;
            block_value_ff    <= pktz ? block_ff : RST_WORD;
            target_node_id_ff <= pktz ? node_high_ff[DATA_W-1 -: NODE_ID_W] : '0;
            target_offset_ff  <= pktz ? {1'b0, node_high_ff[OFS_HI_W-1:0], ofs_low_ff}
                                      : '0;
        end
    end
endmodule

// ===== bench/rxpr_node_model.sv
// rxpr_node_model: remote node giving header quadlets, trailers, block ends
// assumes tb calls its tasks; each pulse is one clk wide
`timescale 1ns/1ps
module rxpr_node_model
    import rxpr_pkg::*;
(
    input  wire logic          clk,
    output rxpr_pkg::rxpr_hdr_s hdr = '0,
    output rxpr_pkg::rxpr_trl_s trl = '0,
    output logic               done = 1'b0
);
    // released lines flip so stale data never looks valid
    task automatic send_hdr(input logic [1:0] i, input logic [31:0] q);
        @(posedge clk) hdr <= '{1'b1, i, q};
        @(posedge clk) hdr <= '{1'b0, ~i, ~q};
    endtask
    task automatic send_trl(input logic [1:0] s, input logic [1:0] f, input logic [3:0] a);
        @(posedge clk) trl <= '{1'b1, s, f, a};
        @(posedge clk) trl <= '{1'b0, ~s, ~f, ~a};
    endtask
    task automatic pulse_done;
        @(posedge clk) done <= 1'b1;
        @(posedge clk) done <= 1'b0;
    endtask
endmodule

// ===== bench/rxpr_regs_chk.sv
// rxpr_regs_chk: port properties of the register bank
// assumes bind onto rxpr_regs, one clock
`timescale 1ns/1ps
module rxpr_regs_chk
    import rxpr_pkg::*;
(
    input wire logic                clk,
    input wire logic                rst,
    input wire rxpr_pkg::rxpr_bus_s bus,
    input wire logic [31:0]         rdata_ff,
    input wire logic                pktz_mode_ff,
    input wire logic                block_is_size_ff,
    input wire logic                count_zero_ff,
    input wire logic [31:0]         block_value_ff,
    input wire logic [47:0]         target_offset_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_rst;
        $past(rst) |-> rdata_ff == 0 && !pktz_mode_ff && block_value_ff == 0;
    endproperty
    a_rst: assert property (p_rst) else $error("not clear after reset");
    property p_size; block_is_size_ff |-> pktz_mode_ff && !count_zero_ff; endproperty
    a_size: assert property (p_size) else $error("size flag wrong");
    property p_cnt; count_zero_ff |-> block_value_ff == 0 && !block_is_size_ff; endproperty
    a_cnt: assert property (p_cnt) else $error("count flag wrong");
    // with no write in flight a change can only be one decrement
    property p_dec; !$past(bus.wr) && !$past(bus.wr, 2) && $past(pktz_mode_ff) && pktz_mode_ff
        && $changed(block_value_ff) |-> block_value_ff == $past(block_value_ff) - 1; endproperty
    a_dec: assert property (p_dec) else $error("block count step wrong");
    property p_lo; $past(bus.wr, 2) && $past(bus.rd) && $past(bus.addr, 2) == OFS_OFS_LOW
        && $past(bus.addr) == OFS_OFS_LOW |-> rdata_ff == $past(bus.wdata, 2); endproperty
    a_lo: assert property (p_lo) else $error("low offset readback wrong");
    property p_trl; $past(bus.rd) && $past(bus.addr) == OFS_TRAILER
        |-> !(rdata_ff & 32'hfffc_fcf0);
    endproperty
    a_trl: assert property (p_trl) else $error("trailer reserved bits set");
    property p_off; !pktz_mode_ff |-> block_value_ff == 0 && target_offset_ff == 0; endproperty
    a_off: assert property (p_off) else $error("control out while mode off");
    // a node register write in mode shows up as the offset top two edges later
    property p_hi; $past(bus.wr, 2) && $past(bus.addr, 2) == OFS_NODE_HIGH && pktz_mode_ff
        |-> target_offset_ff[47:32] == {1'b0, $past(bus.wdata[OFS_HI_W-1:0], 2)}; endproperty
    a_hi: assert property (p_hi) else $error("offset high too wide");
endmodule

// ===== bench/tb.sv
// tb: directed run of the receive packetizer register bank
// assumes rxpr_regs, node model and checker are compiled first
`timescale 1ns/1ps
module tb;
    import rxpr_pkg::*;
    logic              clk = 1'b0, rst = 1'b1, bus_reset = 1'b0, done, pktz_mode_ff;
    logic              block_is_size_ff, count_zero_ff;
    rxpr_bus_s         bus = '0;
    rxpr_hdr_s         hdr;
    rxpr_trl_s         trl;
    logic [31:0]       rdata_ff, block_value_ff;
    logic [16:0]       target_node_id_ff;
    logic [47:0]       target_offset_ff;
    int                failures = 0, checks_done = 0;
    always #12.5 clk = ~clk;
    rxpr_node_model m (.clk, .hdr, .trl, .done);
    rxpr_regs dut (.clk, .rst, .bus, .rdata_ff, .bus_reset, .block_done(done), .hdr_in(hdr),
        .trl_in(trl), .pktz_mode_ff, .block_is_size_ff, .count_zero_ff, .block_value_ff,
        .target_node_id_ff, .target_offset_ff);
    task automatic cmp(input logic [47:0] g, input logic [47:0] e);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // every write is followed by a read or another write, which replaces the strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk) bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk) bus <= '0;
        @(negedge clk) cmp(48'(rdata_ff), 48'(e));
    endtask
    task automatic t_regs;
        for (int i = 0; i < 10; i++)
            rd(i > 8 ? 8'h10 : i > 7 ? OFS_CTRL : 8'(OFS_BLOCK + 4 * i), 0);
        wr(OFS_NODE_HIGH, 32'h8000_4001);
        rd(OFS_NODE_HIGH, 32'h8000_4001);
        wr(OFS_OFS_LOW, 32'h1234_5678);
        rd(OFS_OFS_LOW, 32'h1234_5678);
        wr(OFS_HDR0, 32'hffff_ffff);
        rd(OFS_HDR0, 0);
        wr(OFS_CTRL, 32'h1);
        rd(OFS_CTRL, 32'h1);
        cmp(48'(target_node_id_ff), 48'h1_0000);
        cmp(target_offset_ff, 48'h4001_1234_5678);
        wr(OFS_BLOCK, 32'h2);
        rd(OFS_BLOCK, 32'h2);
        repeat (3) m.pulse_done();
        rd(OFS_BLOCK, 0);
        cmp(48'(count_zero_ff), 48'h1);
        wr(OFS_CTRL, 32'h3);
        wr(OFS_BLOCK, 32'h200);
        rd(OFS_BLOCK, 32'h200);
        m.pulse_done();
        rd(OFS_BLOCK, 32'h200);
        cmp(48'(block_is_size_ff), 48'h1);
        cmp(48'(block_value_ff), 48'h200);
        $display("t_regs done");
    endtask
    task automatic t_rx;
        m.send_hdr(2'd0, 32'haaaa_5555);
        rd(OFS_HDR0, 0);
        wr(OFS_CTRL, 32'h5);
        rd(OFS_CTRL, 32'h5);
        wr(OFS_NODE_HIGH, 32'h0001_7ffe);
        rd(OFS_NODE_HIGH, 32'h0001_7ffe);
        cmp(target_offset_ff, 48'h7ffe_1234_5678);
        cmp(48'(target_node_id_ff), 48'h2);
        for (int i = 0; i < HDR_N; i++)
            m.send_hdr(2'(i), 32'h1111_1111 * (i + 1));
        bus_reset <= 1'b1;
        for (int i = 0; i < HDR_N; i++)
            rd(8'(OFS_HDR0 + 4 * i), 32'h1111_1111 * (i + 1));
        rd(OFS_NODE_HIGH, 32'h0001_7ffe);
        bus_reset <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            m.send_trl(2'(i % 3), 2'(i), 4'(i * 5));
            rd(OFS_TRAILER, {14'h0, 2'(i % 3), 6'h0, 2'(i), 4'h0, 4'(i * 5)});
        end
        wr(OFS_CTRL, 0);
        rd(OFS_CTRL, 0);
        m.send_trl(2'd1, 2'd1, 4'h1);
        rd(OFS_TRAILER, 32'h0000_030f);
        cmp(48'(pktz_mode_ff), 48'h0);
        cmp(48'(block_value_ff), 48'h0);
        $display("t_rx done");
    endtask
    task automatic end_sim;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_rx();
        end_sim();
    end
endmodule
bind rxpr_regs rxpr_regs_chk u_chk (.clk, .rst, .bus, .rdata_ff, .pktz_mode_ff, .block_is_size_ff,
    .count_zero_ff, .block_value_ff, .target_offset_ff);
